/* File: include/spb_pkg.sv */
// package for the banked serial port register file
// assumes an 8-bit register window with 3-bit offsets
package spb_pkg;

  // --------------------------------------------------------------
  // offsets within the shared window
  // --------------------------------------------------------------
  localparam logic [2:0] OFS_0 = 3'h0;          // offset 00h
  localparam logic [2:0] OFS_1 = 3'h1;          // offset 01h
  localparam logic [2:0] OFS_2 = 3'h2;          // offset 02h
  localparam logic [2:0] OFS_BANK_SELECT = 3'h3; // common selector
  localparam logic [2:0] OFS_4 = 3'h4;          // offset 04h
  localparam logic [2:0] OFS_6 = 3'h6;          // offset 06h
  localparam logic [2:0] OFS_7 = 3'h7;          // offset 07h

  // --------------------------------------------------------------
  // field positions and reset values
  // --------------------------------------------------------------
  localparam int          BANK_SELECT_ENABLE_BIT = 7;     // selector enable
  localparam logic [7:0]  RST_BYTE       = 8'h00;         // plain reset
  localparam logic [7:0]  RST_SELECTOR   = 8'h00;         // bank 0 after reset
  localparam logic [7:0]  RST_DIVISOR_LOW = 8'h01;        // divisor of one
  localparam logic [7:0]  MODULE_REVISION = 8'h5A;        // arbitrary value
  localparam logic [7:0]  MASK_FIFO_LEVEL = 8'h1F;        // five-bit count
  localparam logic [7:0]  MASK_PULSE_WIDTH = 8'h0F;       // four-bit width
  localparam logic [7:0]  MASK_FIFO_CONTROL = 8'hF7;      // bit 3 reserved
  localparam logic [7:0]  MASK_EXT_CONTROL_ONE = 8'hB1;   // writable bits
  localparam logic [7:0]  MASK_EXT_CONTROL_TWO = 8'hB0;   // writable bits
  localparam logic [7:0]  MASK_IR_CONTROL_ONE = 8'h0C;    // writable bits
  localparam logic [7:0]  MASK_IR_CONTROL_TWO = 8'h11;    // writable bits
  localparam logic [7:0]  MASK_IR_CONTROL_THREE = 8'hC0;  // writable bits
  localparam logic [7:0]  MASK_IR_CONFIG_THREE = 8'h77;   // writable bits
  localparam logic [7:0]  MASK_IR_CONFIG_FOUR = 8'hBC;    // writable bits
  localparam int          NUM_BANKS = 8;                  // banks 0 to 7

  // --------------------------------------------------------------
  // bank numbers
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    SPB_BANK0 = 3'b000,
    SPB_BANK1 = 3'b001,
    SPB_BANK2 = 3'b010,
    SPB_BANK3 = 3'b011,
    SPB_BANK4 = 3'b100,
    SPB_BANK5 = 3'b101,
    SPB_BANK6 = 3'b110,
    SPB_BANK7 = 3'b111
  } spb_bank_t;

  // register access request
  typedef struct packed {
    logic [2:0] addr;   // offset in window
    logic [7:0] wdata;  // write byte
    logic       wr;     // write strobe
    logic       rd;     // read strobe
  } spb_req_t;

  // ir control bundle exported to the ir engine
  typedef struct packed {
    logic [7:0] ir_control_one;
    logic [7:0] ir_control_two;
    logic [7:0] ir_control_three;
    logic [7:0] sir_pulse_width;
    logic [7:0] ir_config_one;
    logic [7:0] ir_config_three;
    logic [7:0] ir_config_four;
  } spb_ir_cfg_t;

endpackage

/* File: rtl/spb_regs.sv */
// banked register file of the second serial port, banks 1 to 7 plus selector
// assumes the port datapath supplies fifo levels and read-only ir values
//
// How it works
// [R1] eight banks of eight byte registers
// [R2] banks 0-3 uart+ir, 4-7 ir only
// [R3] all banks decode offsets 00h to 07h
// [R4] bank selector at 03h in every bank
// [R5] one or two dma channels supported
// [R6] software uses one channel for ir
// [R7] bank 3 01h mirrors line control
// [R8] bank 3 02h mirrors last fifo control
// [R9] bank 2 06h transmit level, five bits
// [R10] bank 6 02h holds sir pulse width
// [R11] bank 7 00h-02h are read-only
// [R12] bit 7 clear selects bank zero
// [R13] reserved offsets read zero, ignore writes
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none

module spb_regs
  import spb_pkg::*;
(
  input  wire logic              clk,              // 200 MHz register clock
  input  wire logic              rst_n,            // async reset, active low
  input  wire spb_pkg::spb_req_t req,              // host access
  input  wire logic [7:0]        fifo_control_wr,  // byte written to bank 0 fifo control
  input  wire logic              fifo_control_we,  // pulse: fifo control written
  input  wire logic [4:0]        tx_level,         // transmit fifo fill, same clock
  input  wire logic [4:0]        rx_level,         // receive fifo fill, same clock
  input  wire logic [7:0]        demod_value,      // demodulator control readback
  input  wire logic [7:0]        mod_value,        // modulator control readback
  input  wire logic [7:0]        cir_value,        // consumer ir config readback
  output logic [7:0]             rdata,            // read data, cycle after strobe
  output spb_pkg::spb_bank_t     active_bank,      // bank now selected
  output logic [7:0]             line_control,     // line control / selector byte
  output logic [15:0]            legacy_divisor,   // bank 1 divisor
  output logic [15:0]            divisor,          // bank 2 divisor
  output logic [7:0]             ext_control_one,  // extended control one
  output logic [7:0]             ext_control_two,  // extended control two
  output logic                   dual_dma,         // both dma channels in use
  output spb_pkg::spb_ir_cfg_t   ir_cfg            // ir control bundle
);
  import spb_pkg::*;

  // ------------------------------------------------------------------
  // bank decode
  // ------------------------------------------------------------------
  spb_bank_t  next_bank;      // bank from selector byte
  logic [7:0] fifo_shadow;    // last fifo control write
  logic       wr_sel;         // write to selector
  logic [NUM_BANKS-1:0] bank_hit; // one-hot bank decode

  // decode the selector byte; odd encodings fall back to bank 1
  always_comb begin
    if (!line_control[BANK_SELECT_ENABLE_BIT]) begin
      next_bank = SPB_BANK0;                                   // see [R12]
    end else if (!line_control[6]) begin
      next_bank = SPB_BANK1;                                   // see [R12]
    end else if (line_control[1:0] != 2'b00) begin
      next_bank = SPB_BANK1;                                   // see [R12]
    end else begin
      case (line_control[5:2])
        4'b1000: next_bank = SPB_BANK2;
        4'b1001: next_bank = SPB_BANK3;
        4'b1010: next_bank = SPB_BANK4;
        4'b1011: next_bank = SPB_BANK5;
        4'b1100: next_bank = SPB_BANK6;
        4'b1101: next_bank = SPB_BANK7;
        default: next_bank = SPB_BANK1;                        // undefined code
      endcase
    end
  end

  // one-hot bank hit, one term per bank
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi++) begin : g_hit
      assign bank_hit[gi] = (next_bank == spb_bank_t'(gi));    // see [R1]
    end
  endgenerate

  // selector write is bank independent
  assign wr_sel = req.wr && (req.addr == OFS_BANK_SELECT);     // see [R4]

  // ------------------------------------------------------------------
  // selector / line control
  // ------------------------------------------------------------------
  // this byte is the only one seen from every bank
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_control <= RST_SELECTOR;
    end else if (wr_sel) begin
      line_control <= req.wdata;                               // see [R4]
    end
  end

  // registered bank output so the top drives from a flop
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_bank <= SPB_BANK0;
    end else begin
      active_bank <= next_bank;                                // see [R2]
    end
  end

  // ------------------------------------------------------------------
  // bank 1 and bank 2 uart registers
  // ------------------------------------------------------------------
  // divisors; bank decode uses the current selector, so a write that
  // changes banks takes effect from the next access on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      legacy_divisor <= {RST_BYTE, RST_DIVISOR_LOW};
      divisor        <= {RST_BYTE, RST_DIVISOR_LOW};
    end else if (req.wr) begin
      if (bank_hit[1] && req.addr == OFS_0) begin
        legacy_divisor[7:0] <= req.wdata;                      // see [R3]
      end
      if (bank_hit[1] && req.addr == OFS_1) begin
        legacy_divisor[15:8] <= req.wdata;
      end
      if (bank_hit[2] && req.addr == OFS_0) begin
        divisor[7:0] <= req.wdata;
      end
      if (bank_hit[2] && req.addr == OFS_1) begin
        divisor[15:8] <= req.wdata;
      end
    end
  end

  // extended controls in bank 2
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_control_one <= RST_BYTE;
      ext_control_two <= RST_BYTE;
    end else if (req.wr && bank_hit[2]) begin
      if (req.addr == OFS_2) begin
        ext_control_one <= req.wdata & MASK_EXT_CONTROL_ONE;
      end
      if (req.addr == OFS_4) begin
        ext_control_two <= req.wdata & MASK_EXT_CONTROL_TWO;
      end
    end
  end

  // ------------------------------------------------------------------
  // fifo control shadow
  // ------------------------------------------------------------------
  // the fifo control byte is write-only, so software needs this copy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_shadow <= RST_BYTE;
    end else if (fifo_control_we) begin
      fifo_shadow <= fifo_control_wr & MASK_FIFO_CONTROL;      // see [R8]
    end
  end

  // ------------------------------------------------------------------
  // ir control registers, banks 4 to 7
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_cfg <= '0;
    end else if (req.wr) begin
      if (bank_hit[4] && req.addr == OFS_2) begin
        ir_cfg.ir_control_one <= req.wdata & MASK_IR_CONTROL_ONE;
      end
      if (bank_hit[5] && req.addr == OFS_4) begin
        ir_cfg.ir_control_two <= req.wdata & MASK_IR_CONTROL_TWO;
      end
      if (bank_hit[6] && req.addr == OFS_0) begin
        ir_cfg.ir_control_three <= req.wdata & MASK_IR_CONTROL_THREE;
      end
      if (bank_hit[6] && req.addr == OFS_2) begin
        ir_cfg.sir_pulse_width <= req.wdata & MASK_PULSE_WIDTH; // see [R10]
      end
      if (bank_hit[7] && req.addr == OFS_4) begin
        ir_cfg.ir_config_one <= req.wdata;
      end
      if (bank_hit[7] && req.addr == OFS_6) begin
        ir_cfg.ir_config_three <= req.wdata & MASK_IR_CONFIG_THREE;
      end
      if (bank_hit[7] && req.addr == OFS_7) begin
        ir_cfg.ir_config_four <= req.wdata & MASK_IR_CONFIG_FOUR;
      end
      // bank 7 offsets 00h-02h take no write at all, see [R11]
      // other offsets fall through untouched, see [R13]
    end
  end

  // dual dma when the full-duplex bit of ir control two is set;
  // software is expected to keep it clear for ir work
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dual_dma <= 1'b0;
    end else begin
      dual_dma <= ir_cfg.ir_control_two[0];                    // see [R5]
    end
  end

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  logic [7:0] next_rdata;  // byte chosen this cycle

  // reserved or bank 0 datapath offsets return zero
  always_comb begin
    next_rdata = 8'h00;                                        // see [R13]
    if (req.addr == OFS_BANK_SELECT) begin
      next_rdata = line_control;                               // see [R4]
    end else begin
      case (next_bank)
        SPB_BANK1: begin
          if (req.addr == OFS_0) next_rdata = legacy_divisor[7:0];
          if (req.addr == OFS_1) next_rdata = legacy_divisor[15:8];
        end
        SPB_BANK2: begin
          case (req.addr)
            OFS_0:   next_rdata = divisor[7:0];
            OFS_1:   next_rdata = divisor[15:8];
            OFS_2:   next_rdata = ext_control_one;
            OFS_4:   next_rdata = ext_control_two;
            OFS_6:   next_rdata = {3'h0, tx_level} & MASK_FIFO_LEVEL; // see [R9]
            OFS_7:   next_rdata = {3'h0, rx_level} & MASK_FIFO_LEVEL;
            default: next_rdata = 8'h00;
          endcase
        end
        SPB_BANK3: begin
          case (req.addr)
            OFS_0:   next_rdata = MODULE_REVISION;
            OFS_1:   next_rdata = line_control;                // see [R7]
            OFS_2:   next_rdata = fifo_shadow;                 // see [R8]
            default: next_rdata = 8'h00;
          endcase
        end
        SPB_BANK4: begin
          if (req.addr == OFS_2) next_rdata = ir_cfg.ir_control_one;
        end
        SPB_BANK5: begin
          if (req.addr == OFS_4) next_rdata = ir_cfg.ir_control_two;
        end
        SPB_BANK6: begin
          if (req.addr == OFS_0) next_rdata = ir_cfg.ir_control_three;
          if (req.addr == OFS_2) next_rdata = ir_cfg.sir_pulse_width;
        end
        SPB_BANK7: begin
          case (req.addr)
            OFS_0:   next_rdata = demod_value;                 // see [R11]
            OFS_1:   next_rdata = mod_value;
            OFS_2:   next_rdata = cir_value;
            OFS_4:   next_rdata = ir_cfg.ir_config_one;
            OFS_6:   next_rdata = ir_cfg.ir_config_three;
            OFS_7:   next_rdata = ir_cfg.ir_config_four;
            default: next_rdata = 8'h00;
          endcase
        end
        default: next_rdata = 8'h00;                           // bank 0 lives elsewhere
      endcase
    end
  end

  // read data held only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule // spb_regs

`default_nettype wire

/* File: verification/spb_regs_checker.sv */
// concurrent checks for the banked serial port register file
// assumes a bind onto spb_regs and sight of its ports only
`timescale 1ns/100ps
`default_nettype none

module spb_regs_checker (
  input wire logic                 clk,             // register clock
  input wire logic                 rst_n,           // async reset, active low
  input wire spb_pkg::spb_req_t    req,             // host access
  input wire logic [7:0]           fifo_control_wr, // fifo control byte
  input wire logic                 fifo_control_we, // fifo control strobe
  input wire logic [4:0]           tx_level,        // transmit fill
  input wire logic [4:0]           rx_level,        // receive fill
  input wire logic [7:0]           demod_value,     // read-only source
  input wire logic [7:0]           mod_value,       // read-only source
  input wire logic [7:0]           cir_value,       // read-only source
  input wire logic [7:0]           rdata,           // read answer
  input wire spb_pkg::spb_bank_t   active_bank,     // selected bank
  input wire logic [7:0]           line_control,    // selector byte
  input wire logic [15:0]          legacy_divisor,  // bank 1 divisor
  input wire logic [15:0]          divisor,         // bank 2 divisor
  input wire logic [7:0]           ext_control_one, // extended control
  input wire logic [7:0]           ext_control_two, // extended control
  input wire logic                 dual_dma,        // both channels
  input wire spb_pkg::spb_ir_cfg_t ir_cfg           // ir bundle
);
  import spb_pkg::*;

  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  logic [7:0] fifo_seen; // last fifo control byte, shadow model
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) fifo_seen <= 8'h00;
    else if (fifo_control_we) fifo_seen <= fifo_control_wr;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  AST_RDATA_IDLE: assert property (!req.rd |=> rdata == 8'h00)
    else $error("rdata not zero outside a read answer");
  AST_SEL_WRITE: assert property (req.wr && req.addr == OFS_BANK_SELECT
    |=> line_control == $past(req.wdata)) else $error("selector write lost");
  AST_SEL_READ: assert property (req.rd && req.addr == OFS_BANK_SELECT
    |=> rdata == $past(line_control)) else $error("selector read wrong");
  AST_BANK_ZERO: assert property (!line_control[7] && $stable(line_control)
    |-> active_bank == SPB_BANK0) else $error("bank zero not selected");
  AST_TX_LEVEL: assert property (req.rd && req.addr == OFS_6
    && line_control == 8'hE0
    |=> rdata == {3'h0, $past(tx_level)}) else $error("transmit level wrong");
  AST_LINE_SHADOW: assert property (req.rd && req.addr == OFS_1
    && line_control == 8'hE4
    |=> rdata == $past(line_control)) else $error("line control shadow wrong");
  AST_FIFO_SHADOW: assert property (req.rd && req.addr == OFS_2
    && line_control == 8'hE4
    |=> rdata == ($past(fifo_seen) & MASK_FIFO_CONTROL)) else $error("fifo shadow wrong");
  AST_RO_DEMOD: assert property (req.rd && req.addr == OFS_0
    && line_control == 8'hF4
    |=> rdata == $past(demod_value)) else $error("demodulator readback wrong");
  AST_PULSE_WIDTH: assert property (req.wr && req.addr == OFS_2
    && line_control == 8'hF0
    |=> ir_cfg.sir_pulse_width == ($past(req.wdata) & MASK_PULSE_WIDTH))
    else $error("pulse width not stored");
  AST_DUAL_DMA: assert property ($stable(ir_cfg.ir_control_two)
    |-> dual_dma == ir_cfg.ir_control_two[0]) else $error("dma channel mode wrong");
  AST_RESERVED: assert property (req.rd && line_control == 8'h80
    && (req.addr == OFS_2 || req.addr >= OFS_4) |=> rdata == 8'h00)
    else $error("reserved offset not zero");

  // main scenarios reached
  cover property (req.rd && line_control == 8'hF4);
  cover property (req.rd && req.addr == OFS_6 && line_control == 8'hE0);
  cover property (req.wr && req.addr == OFS_2 && line_control == 8'hF0);
endmodule // spb_regs_checker

bind spb_regs spb_regs_checker i_checker (.clk(clk), .rst_n(rst_n), .req(req),
  .fifo_control_wr(fifo_control_wr), .fifo_control_we(fifo_control_we),
  .tx_level(tx_level), .rx_level(rx_level), .demod_value(demod_value),
  .mod_value(mod_value), .cir_value(cir_value), .rdata(rdata), .active_bank(active_bank),
  .line_control(line_control), .legacy_divisor(legacy_divisor), .divisor(divisor),
  .ext_control_one(ext_control_one), .ext_control_two(ext_control_two),
  .dual_dma(dual_dma), .ir_cfg(ir_cfg));
`default_nettype wire

/* File: verification/spb_host.sv */
// host software model driving the register window
// assumes one-cycle strobes and read data in the cycle after
`timescale 1ns/100ps
`default_nettype none

module spb_host (
  input  wire logic          clk,   // register clock
  output var spb_pkg::spb_req_t req,   // access toward the register file
  input  wire logic [7:0]    rdata  // answer one cycle after a read
);
  import spb_pkg::*;
  initial req = '0;

  // ------------------------------------------------------------
  // bus cycles
  // ------------------------------------------------------------
  // idle lines carry inverted data so a stale value never looks valid
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    req <= '{addr: ~a, wdata: ~d, wr: 1'h0, rd: 1'h0};
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    req <= '{addr: ~a, wdata: 8'hFF, wr: 1'h0, rd: 1'h0};
    #1 d = rdata;
  endtask

  // infrared is half duplex, so one dma channel is enough
  task automatic ir_mode();
    wr(OFS_BANK_SELECT, 8'hEC);
    wr(OFS_4, 8'h00);
  endtask
endmodule // spb_host
`default_nettype wire

/* File: verification/spb_regs_tb_top.sv */
// self-checking bench for the banked serial port register file
// assumes the host model and checker files are compiled first
`timescale 1ns/100ps
`default_nettype none

module spb_regs_tb_top;
  import spb_pkg::*;
  logic              clk = 1'h0;             // 200 MHz clock
  logic              rst_n = 1'h0;           // async reset
  spb_req_t          req;                    // host request
  logic [7:0]        fifo_control_wr = 8'h00; // fifo control byte
  logic              fifo_control_we = 1'h0; // fifo control strobe
  logic [4:0]        tx_level = 5'h00;       // transmit fill
  logic [4:0]        rx_level = 5'h00;       // receive fill
  logic [7:0]        demod_value = 8'h00;    // read-only sources
  logic [7:0]        mod_value = 8'h00;
  logic [7:0]        cir_value = 8'h00;
  logic [7:0]        rdata, line_control, got;
  spb_bank_t         active_bank;
  logic [15:0]       legacy_divisor, divisor;
  logic              dual_dma;
  logic [7:0]        ext_control_one, ext_control_two; // extended controls
  spb_ir_cfg_t       ir_cfg;
  int                err_total = 0;          // mismatches
  int                samples_checked = 0;    // comparisons
  logic [7:0] sel_code [10] = '{8'h00, 8'h80, 8'hC1, 8'hC2, 8'hE0,
                                8'hE4, 8'hE8, 8'hEC, 8'hF0, 8'hF4};
  logic [2:0] sel_bank [10] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};

  always #2.5 clk = ~clk;

  spb_host i_host (.clk(clk), .req(req), .rdata(rdata));
  spb_regs i_dut (.clk(clk), .rst_n(rst_n), .req(req), .fifo_control_wr(fifo_control_wr),
    .fifo_control_we(fifo_control_we), .tx_level(tx_level), .rx_level(rx_level),
    .demod_value(demod_value), .mod_value(mod_value), .cir_value(cir_value),
    .rdata(rdata), .active_bank(active_bank), .line_control(line_control),
    .legacy_divisor(legacy_divisor), .divisor(divisor), .ext_control_one(ext_control_one),
    .ext_control_two(ext_control_two), .dual_dma(dual_dma), .ir_cfg(ir_cfg));

  // ------------------------------------------------------------
  // comparison and verdict
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
    i_host.rd(a, got);
    check({8'h00, got}, {8'h00, exp});
  endtask

  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // time limit: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    #1 check(divisor, 16'h0001);
    check(active_bank, SPB_BANK0);
    // every code in sel_code, read back through the common offset
    for (int i = 0; i < 10; i++) begin
      i_host.wr(OFS_BANK_SELECT, sel_code[i]);
      @(posedge clk);
      #1 check(active_bank, sel_bank[i]);
      rdchk(OFS_BANK_SELECT, sel_code[i]);
    end
    // bank 1: legacy divisor bytes, reserved offsets stay zero
    i_host.wr(OFS_BANK_SELECT, 8'h80);
    i_host.wr(OFS_0, 8'h34);
    i_host.wr(OFS_1, 8'h12);
    i_host.wr(OFS_2, 8'hFF);
    #1 check(legacy_divisor, 16'h1234);
    rdchk(OFS_2, 8'h00);
    rdchk(OFS_7, 8'h00);
    // bank 2: divisor, extended controls and fifo levels
    i_host.wr(OFS_BANK_SELECT, 8'hE0);
    tx_level <= 5'h13;
    rx_level <= 5'h1F;
    i_host.wr(OFS_0, 8'hCD);
    #1 check(divisor, 16'h00CD);
    i_host.wr(OFS_2, 8'hFF);
    i_host.wr(OFS_4, 8'hFF);
    #1 check(ext_control_one, MASK_EXT_CONTROL_ONE);
    check(ext_control_two, MASK_EXT_CONTROL_TWO);
    rdchk(OFS_2, MASK_EXT_CONTROL_ONE);
    rdchk(OFS_4, MASK_EXT_CONTROL_TWO);
    rdchk(OFS_6, 8'h13);
    rdchk(OFS_7, 8'h1F);
    rdchk(3'h5, 8'h00);
    // bank 3: line control shadow ignores a write, fifo shadow follows fifo control
    i_host.wr(OFS_BANK_SELECT, 8'hE4);
    fifo_control_wr <= 8'hFF;
    fifo_control_we <= 1'h1;
    @(posedge clk);
    fifo_control_we <= 1'h0;
    i_host.wr(OFS_1, 8'h00);
    rdchk(OFS_2, 8'hFF & MASK_FIFO_CONTROL);
    rdchk(OFS_1, 8'hE4);
    rdchk(OFS_0, MODULE_REVISION);
    // bank 4: ir control one keeps only its fields
    i_host.wr(OFS_BANK_SELECT, 8'hE8);
    i_host.wr(OFS_2, 8'hFF);
    #1 check(ir_cfg.ir_control_one, MASK_IR_CONTROL_ONE);
    rdchk(OFS_2, MASK_IR_CONTROL_ONE);
    rdchk(OFS_0, 8'h00);
    // bank 6: pulse width and ir control three keep only their fields
    i_host.wr(OFS_BANK_SELECT, 8'hF0);
    i_host.wr(OFS_0, 8'hFF);
    i_host.wr(OFS_2, 8'hFF);
    #1 check(ir_cfg.sir_pulse_width, 8'h0F);
    check(ir_cfg.ir_control_three, MASK_IR_CONTROL_THREE);
    rdchk(OFS_2, 8'h0F);
    rdchk(OFS_0, MASK_IR_CONTROL_THREE);
    rdchk(OFS_1, 8'h00);
    // bank 5: one or both dma channels
    i_host.wr(OFS_BANK_SELECT, 8'hEC);
    i_host.wr(OFS_4, 8'h01);
    repeat (2) @(posedge clk);
    #1 check(dual_dma, 1'h1);
    rdchk(OFS_4, 8'h01);
    i_host.ir_mode();
    repeat (2) @(posedge clk);
    #1 check(dual_dma, 1'h0);
    // bank 7: read-only sources, writes ignored
    i_host.wr(OFS_BANK_SELECT, 8'hF4);
    demod_value <= 8'hA5;
    mod_value <= 8'h3C;
    cir_value <= 8'h96;
    for (int a = 0; a < 3; a++) begin
      i_host.wr(a[2:0], 8'h00);
    end
    rdchk(OFS_0, 8'hA5);
    rdchk(OFS_1, 8'h3C);
    rdchk(OFS_2, 8'h96);
    // bank 7: config one takes the whole byte, config three and four keep only their fields
    i_host.wr(OFS_4, 8'hFF);
    i_host.wr(OFS_6, 8'hFF);
    i_host.wr(OFS_7, 8'hFF);
    #1 check(ir_cfg.ir_config_one, 8'hFF);
    rdchk(OFS_4, 8'hFF);
    rdchk(OFS_6, MASK_IR_CONFIG_THREE);
    rdchk(OFS_7, MASK_IR_CONFIG_FOUR);
    rdchk(3'h5, 8'h00);
    // reset in mid-run brings the selector, the active bank and the bank 1 legacy divisor back
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    #1 check(line_control, RST_SELECTOR);
    check(legacy_divisor, {RST_BYTE, RST_DIVISOR_LOW});
    check(active_bank, SPB_BANK0);
    rdchk(OFS_BANK_SELECT, RST_SELECTOR);
    print_verdict();
  end
endmodule // spb_regs_tb_top
`default_nettype wire
